// ### hw/purs_top.sv
// Purpose: Power-up, brownout and nested reset sequencing with clock enables
// Assumes: Detector comparator outputs arrive asynchronously on pins
// Notes:   Software level writes come as a plain strobe and data pair
`timescale 1ns/1ps
// Contract
// [R01] Power-on release starts bandgap and brownout detector
// [R02] Lowest brownout release continues boot, starts POWER_MANAGEMENT_UNIT
// [R03] Four brownout levels, numbered upward
// [R04] Every startup uses lowest brownout level
// [R05] After boot software may raise level
// [R06] Five nested reset levels
// [R07] Real-time clock reset by boot, brownout, power-on
// [R08] Fixed 4 MHz clock enable, synchronous
// [R09] Low-power domain clock derived from main clock
// [R10] Raised level fall: interrupt, back to lowest
module purs_top
  import purs_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Supply detector pins
  input  wire logic                 por_ok_pin,
  input  wire logic                 bor_low_ok_pin,
  input  wire logic                 bor_sel_ok_pin,
  // Software controls
  input  wire logic                 level_wr,
  input  wire logic [BOR_LVL_W-1:0] level_din,
  input  wire logic                 boot_rst_req,
  input  wire logic                 sys_rst_req,
  input  wire logic                 cpu_rst_req,
  // Analog enables
  output logic                      bandgap_en,
  output logic                      brownout_det_en,
  output logic                      power_management_unit_en,
  output logic [BOR_LVL_W-1:0]      bor_level,
  // Reset levels
  output logic                      por_reset,
  output logic                      bor_reset,
  output logic                      boot_level_reset,
  output logic                      system_level_reset,
  output logic                      processor_level_reset,
  output logic                      rtc_reset,
  // Status and events
  output logic                      boot_done,
  output logic                      bor_irq,
  // Clock enables
  output logic                      fixed_middle_clock_en,
  output logic                      low_power_domain_clock_en
);

  logic                 por_ok;
  logic                 bor_low_ok;
  logic                 bor_sel_ok;
  purs_state_t          st_q;
  purs_state_t          st_d;
  logic [TMR_W-1:0]     boot_cnt_q;
  purs_pulse_t          pk_q;
  logic [TMR_W-1:0]     pk_cnt_q;
  logic [BOR_LVL_W-1:0] lvl_q;
  logic                 bor_irq_q;
  logic                 raised_fall;
  logic [ACC_W-1:0]     acc_q;
  logic [ACC_W:0]       acc_sum;
  logic                 mid_en_q;
  logic [3:0]           lp_cnt_q;
  logic                 lp_en_q;

  // Detector pin synchronisers
  purs_sync u_sync_por (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  (por_ok_pin),
    .level_q (por_ok)
  );
  purs_sync u_sync_lowest_brownout_level (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  (bor_low_ok_pin),
    .level_q (bor_low_ok)
  );
  purs_sync u_sync_bsel (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  (bor_sel_ok_pin),
    .level_q (bor_sel_ok)
  );

  // Fall below a raised threshold while running
  assign raised_fall = (st_q == ST_RUN) && (lvl_q != LOWEST_BROWNOUT_LEVEL)
                       && !bor_sel_ok; // [R10]

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_POR:  if (por_ok) st_d = ST_BOR; // [R01]
      ST_BOR:  if (bor_low_ok) st_d = ST_BOOT; // [R02]
      ST_BOOT: if (boot_cnt_q == TMR_ZERO) st_d = ST_RUN;
      ST_RUN:  if (boot_rst_req) st_d = ST_BOOT;
      default: st_d = ST_POR;
    endcase
    if (st_q != ST_POR && !bor_low_ok) st_d = ST_BOR; // [R10]
    if (!por_ok) st_d = ST_POR;
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (!rst_n) st_q <= ST_POR;
    else        st_q <= st_d;
  end

  // Boot reset hold timer, reloaded on every entry to boot
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_cnt_q <= BOOT_LOAD;
    end else if (st_d == ST_BOOT && st_q != ST_BOOT) begin
      boot_cnt_q <= BOOT_LOAD;
    end else if (st_q == ST_BOOT && boot_cnt_q != TMR_ZERO) begin
      boot_cnt_q <= boot_cnt_q - 8'h01;
    end
  end

  // Software system or processor reset pulse; system wins
  always_ff @(posedge clk) begin
    if (!rst_n || st_q != ST_RUN) begin
      pk_q     <= PK_NONE;
      pk_cnt_q <= TMR_ZERO;
    end else if (sys_rst_req) begin
      pk_q     <= PK_SYS;
      pk_cnt_q <= SWRST_LOAD;
    end else if (cpu_rst_req && pk_q != PK_SYS) begin
      pk_q     <= PK_CPU;
      pk_cnt_q <= SWRST_LOAD;
    end else if (pk_cnt_q != TMR_ZERO) begin
      pk_cnt_q <= pk_cnt_q - 8'h01;
    end else begin
      pk_q     <= PK_NONE;
    end
  end

  // Brownout level: lowest at every startup, writable after boot
  // Cleared on the edge that leaves run, so no raised level leaks into a restart
  always_ff @(posedge clk) begin
    if (!rst_n || st_q != ST_RUN || st_d != ST_RUN) begin
      lvl_q <= LOWEST_BROWNOUT_LEVEL; // [R04]
    end else if (raised_fall) begin
      lvl_q <= LOWEST_BROWNOUT_LEVEL; // [R10]
    end else if (level_wr) begin
      lvl_q <= level_din; // [R05] [R03]
    end
  end

  // One-cycle interrupt on a raised-level fall
  always_ff @(posedge clk) begin
    if (!rst_n) bor_irq_q <= 1'b0;
    else        bor_irq_q <= raised_fall; // [R10]
  end

  // Fixed middle clock enable, 4 of every 25 main cycles
  assign acc_sum = {1'b0, acc_q} + {1'b0, MID_STEP};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q    <= ACC_ZERO;
      mid_en_q <= 1'b0;
    end else if (acc_sum >= {1'b0, MID_MOD}) begin
      acc_q    <= acc_sum[ACC_W-1:0] - MID_MOD; // [R08]
      mid_en_q <= 1'b1;
    end else begin
      acc_q    <= acc_sum[ACC_W-1:0];
      mid_en_q <= 1'b0;
    end
  end

  // Low-power domain clock enable divided from the main clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lp_cnt_q <= LP_ZERO;
      lp_en_q  <= 1'b0;
    end else begin
      lp_cnt_q <= (lp_cnt_q == LP_LAST) ? LP_ZERO : lp_cnt_q + 4'h1; // [R09]
      lp_en_q  <= (lp_cnt_q == LP_LAST);
    end
  end

  // Analog enables follow the sequence
  assign bandgap_en               = (st_q != ST_POR); // [R01]
  assign brownout_det_en          = (st_q != ST_POR); // [R01]
  assign power_management_unit_en = (st_q == ST_BOOT) || (st_q == ST_RUN); // [R02]
  assign bor_level                = lvl_q;

  // Nested reset levels; each includes every lower one
  assign por_reset             = (st_q == ST_POR); // [R06]
  assign bor_reset             = por_reset || (st_q == ST_BOR); // [R06]
  assign boot_level_reset      = bor_reset || (st_q == ST_BOOT); // [R06]
  assign system_level_reset    = boot_level_reset || (pk_q == PK_SYS); // [R06]
  assign processor_level_reset = system_level_reset || (pk_q == PK_CPU); // [R06]
  assign rtc_reset             = boot_level_reset; // [R07]

  // Status and enables out
  assign boot_done                 = (st_q == ST_RUN);
  assign bor_irq                   = bor_irq_q;
  assign fixed_middle_clock_en     = mid_en_q;
  assign low_power_domain_clock_en = lp_en_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_por_release;
    (st_q == ST_POR) && por_ok |=> bandgap_en && brownout_det_en;
  endproperty
  a_por_release: assert property (p_por_release) // [R01]
    else $error("no start on power-on release");

  property p_pmu_start;
    (st_q == ST_BOR) && bor_low_ok && por_ok |=> power_management_unit_en && !bor_reset;
  endproperty
  a_pmu_start: assert property (p_pmu_start) // [R02]
    else $error("pmu not started");

  property p_startup_lowest;
    !boot_done |-> bor_level == LOWEST_BROWNOUT_LEVEL;
  endproperty
  a_startup_lowest: assert property (p_startup_lowest) // [R04]
    else $error("startup not lowest");

  property p_level_write;
    boot_done && level_wr && !raised_fall && (st_d == ST_RUN)
      |=> bor_level == $past(level_din);
  endproperty
  a_level_write: assert property (p_level_write) // [R05]
    else $error("level write lost");

  property p_nesting;
    (!por_reset || bor_reset) && (!bor_reset || boot_level_reset)
      && (!boot_level_reset || system_level_reset)
      && (!system_level_reset || processor_level_reset);
  endproperty
  a_nesting: assert property (p_nesting) // [R06]
    else $error("reset levels not nested");

  property p_rtc;
    rtc_reset == ((st_q == ST_POR) || (st_q == ST_BOR) || (st_q == ST_BOOT));
  endproperty
  a_rtc: assert property (p_rtc) // [R07]
    else $error("rtc reset mismatch");

  property p_mid_rate;
    fixed_middle_clock_en |=> !fixed_middle_clock_en ##1 !fixed_middle_clock_en;
  endproperty
  a_mid_rate: assert property (p_mid_rate) // [R08]
    else $error("middle clock too fast");

  property p_mid_present;
    !fixed_middle_clock_en [*7] |=> fixed_middle_clock_en;
  endproperty
  a_mid_present: assert property (p_mid_present) // [R08]
    else $error("middle clock missing");

  property p_lp_div;
    low_power_domain_clock_en |=> !low_power_domain_clock_en ##1 low_power_domain_clock_en;
  endproperty
  a_lp_div: assert property (p_lp_div) // [R09]
    else $error("low-power enable wrong");

  property p_raised_fall;
    raised_fall && bor_low_ok && por_ok && !boot_rst_req
      |=> bor_irq && bor_level == LOWEST_BROWNOUT_LEVEL ##1 !bor_irq;
  endproperty
  a_raised_fall: assert property (p_raised_fall) // [R10]
    else $error("raised fall not handled");

  property p_hold_bor;
    boot_done && !bor_low_ok |=> bor_reset;
  endproperty
  a_hold_bor: assert property (p_hold_bor) // [R10]
    else $error("not held in brownout");

endmodule

// ### include/purs_pkg.sv
// Purpose: Shared constants and types for the power-up reset sequencer
// Assumes: Single 25 MHz clock, synchronous active-low reset
// Notes:   Times are given in their own unit, cycle counts derived here
package purs_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ       = 25;

  // Brownout threshold levels, lowest first
  localparam int unsigned BOR_LVL_W     = 2;
  localparam int unsigned BOR_LVL_NUM   = 4;
  localparam logic [1:0]  LOWEST_BROWNOUT_LEVEL = 2'h0;

  // Boot reset hold time after the lowest brownout release
  localparam int unsigned BOOT_HOLD_NS  = 2000;
  localparam int unsigned BOOT_CYC      = (BOOT_HOLD_NS * CLK_MHZ + 999) / 1000;

  // Software-requested system or processor reset pulse width
  localparam int unsigned SWRST_NS      = 1000;
  localparam int unsigned SWRST_CYC     = (SWRST_NS * CLK_MHZ + 999) / 1000;

  // Pulse timer width and its reload values
  localparam int unsigned TMR_W         = 8;
  localparam logic [7:0]  BOOT_LOAD     = 8'(BOOT_CYC - 1);
  localparam logic [7:0]  SWRST_LOAD    = 8'(SWRST_CYC - 1);
  localparam logic [7:0]  TMR_ZERO      = 8'h00;

  // Fixed middle clock: 4 MHz out of 25 MHz by a fractional accumulator
  localparam int unsigned MID_MHZ       = 4;
  localparam int unsigned ACC_W         = 5;
  localparam logic [4:0]  MID_STEP      = 5'(MID_MHZ);
  localparam logic [4:0]  MID_MOD       = 5'(CLK_MHZ);
  localparam logic [4:0]  ACC_ZERO      = 5'h00;

  // Low-power domain clock: main clock divided by this ratio
  localparam int unsigned LP_DIV        = 2;
  localparam logic [3:0]  LP_LAST       = 4'(LP_DIV - 1);
  localparam logic [3:0]  LP_ZERO       = 4'h0;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_POR,
    ST_BOR,
    ST_BOOT,
    ST_RUN
  } purs_state_t;

  // Kind of the running software reset pulse
  typedef enum logic [1:0] {
    PK_NONE,
    PK_SYS,
    PK_CPU
  } purs_pulse_t;

endpackage

// ### hw/purs_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Input is asynchronous to clk
// Notes:   Output changes only once stages two and three agree
`timescale 1ns/1ps
module purs_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin side
  input  wire logic pin_in,
  // Filtered level
  output logic      level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a new level once two stages agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

endmodule

// ### bench/purs_top_tb.sv
// Purpose: Self-checking bench for the power-up reset sequencer
// Assumes: Inputs driven at falling edges, outputs sampled there too
// Notes:   Supply pins are driven as settled levels, no glitches
`timescale 1ns/1ps
module purs_top_tb;
  import purs_pkg::*;

  // Stimulus and observed signals
  logic                 clk, rst_n, por_ok_pin, bor_low_ok_pin, bor_sel_ok_pin;
  logic                 level_wr, boot_rst_req, sys_rst_req, cpu_rst_req;
  logic [BOR_LVL_W-1:0] level_din, bor_level;
  logic                 bandgap_en, brownout_det_en, power_management_unit_en;
  logic                 por_reset, bor_reset, boot_level_reset, system_level_reset;
  logic                 processor_level_reset, rtc_reset, boot_done, bor_irq;
  logic                 fixed_middle_clock_en, low_power_domain_clock_en;
  int                   err_total, n_compared;

  purs_top purs_top_inst (
    .clk                       (clk),
    .rst_n                     (rst_n),
    .por_ok_pin                (por_ok_pin),
    .bor_low_ok_pin            (bor_low_ok_pin),
    .bor_sel_ok_pin            (bor_sel_ok_pin),
    .level_wr                  (level_wr),
    .level_din                 (level_din),
    .boot_rst_req              (boot_rst_req),
    .sys_rst_req               (sys_rst_req),
    .cpu_rst_req               (cpu_rst_req),
    .bandgap_en                (bandgap_en),
    .brownout_det_en           (brownout_det_en),
    .power_management_unit_en  (power_management_unit_en),
    .bor_level                 (bor_level),
    .por_reset                 (por_reset),
    .bor_reset                 (bor_reset),
    .boot_level_reset          (boot_level_reset),
    .system_level_reset        (system_level_reset),
    .processor_level_reset     (processor_level_reset),
    .rtc_reset                 (rtc_reset),
    .boot_done                 (boot_done),
    .bor_irq                   (bor_irq),
    .fixed_middle_clock_en     (fixed_middle_clock_en),
    .low_power_domain_clock_en (low_power_domain_clock_en)
  );

  // Main clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare one value against its expectation
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Codes of the outputs that the wait helpers watch
  localparam int S_BGAP = 0;
  localparam int S_PMU  = 1;
  localparam int S_IRQ  = 2;
  localparam int S_BOR  = 3;
  localparam int S_DONE = 4;
  localparam int S_BOOT = 5;
  localparam int S_SYS  = 6;
  localparam int S_CPU  = 7;

  // Output picked by its code
  function automatic logic pick(input int k);
    case (k)
      S_BGAP:  pick = bandgap_en;
      S_PMU:   pick = power_management_unit_en;
      S_IRQ:   pick = bor_irq;
      S_BOR:   pick = bor_reset;
      S_DONE:  pick = boot_done;
      S_BOOT:  pick = boot_level_reset;
      S_SYS:   pick = system_level_reset;
      S_CPU:   pick = processor_level_reset;
      default: pick = 1'b0;
    endcase
  endfunction

  // Bounded wait for a level on an output; running out is a mismatch
  task automatic wt(input int k, input logic v);
    for (int i = 0; i < 200 && pick(k) !== v; i++) @(negedge clk);
    if (pick(k) !== v) begin
      err_total++;
      $display("[ERR] t=%0t wait limit seen=%h exp=%h", $time, pick(k), v);
    end
  endtask

  // Count cycles an output stays high
  task automatic hi_len(input int k, output int n);
    n = 0;
    while (pick(k) === 1'b1 && n < 300) begin
      n++;
      @(negedge clk);
    end
  endtask

  // Cold start through power-on, brownout and boot
  task automatic t_power_up();
    int n;
    chk(por_reset, 1'h1);
    chk(rtc_reset, 1'h1);
    chk(bandgap_en, 1'h0);
    chk(bor_level, LOWEST_BROWNOUT_LEVEL);
    por_ok_pin = 1'b1;
    wt(S_BGAP, 1'b1);
    chk({brownout_det_en, por_reset}, 8'h2);
    repeat (3) @(negedge clk);
    chk({power_management_unit_en, bor_reset}, 8'h1);
    bor_low_ok_pin = 1'b1;
    bor_sel_ok_pin = 1'b1;
    wt(S_PMU, 1'b1);
    chk({bor_reset, boot_level_reset, rtc_reset}, 8'h3);
    hi_len(S_BOOT, n);
    chk(8'(n), 8'(BOOT_CYC));
    chk({boot_done, rtc_reset, processor_level_reset}, 8'h4);
  endtask

  // Raise the level, then fall below it
  task automatic t_level();
    level_din = 2'h3;
    level_wr  = 1'b1;
    @(negedge clk);
    level_din = 2'h2;
    chk(bor_level, 8'h3);
    @(negedge clk);
    level_wr = 1'b0;
    chk(bor_level, 8'h2);
    bor_sel_ok_pin = 1'b0;
    wt(S_IRQ, 1'b1);
    chk({bor_irq, bor_level, bor_reset}, 8'h8);
    @(negedge clk);
    chk(bor_irq, 1'h0);
    bor_sel_ok_pin = 1'b1;
  endtask

  // Software system and processor pulses
  task automatic t_swrst();
    int n;
    sys_rst_req = 1'b1;
    @(negedge clk);
    sys_rst_req = 1'b0;
    chk({processor_level_reset, boot_level_reset, rtc_reset}, 8'h4);
    hi_len(S_SYS, n);
    chk(8'(n), 8'(SWRST_CYC));
    cpu_rst_req = 1'b1;
    @(negedge clk);
    cpu_rst_req = 1'b0;
    chk({processor_level_reset, system_level_reset}, 8'h2);
    hi_len(S_CPU, n);
    chk(8'(n), 8'(SWRST_CYC));
  endtask

  // Clock enable rates over 50 cycles
  task automatic t_clocks();
    int m, l;
    m = 0;
    l = 0;
    repeat (50) begin
      @(negedge clk);
      m += int'(fixed_middle_clock_en === 1'b1);
      l += int'(low_power_domain_clock_en === 1'b1);
    end
    chk(8'(m), 8'(2 * MID_STEP));
    chk(8'(l), 8'(50 / LP_DIV));
  endtask

  // Brownout after a raise, recovery, then boot reset request
  task automatic t_brownout();
    level_din = 2'h1;
    level_wr  = 1'b1;
    @(negedge clk);
    level_wr       = 1'b0;
    bor_low_ok_pin = 1'b0;
    bor_sel_ok_pin = 1'b0;
    wt(S_BOR, 1'b1);
    chk({rtc_reset, power_management_unit_en, por_reset}, 8'h4);
    chk(bor_level, LOWEST_BROWNOUT_LEVEL);
    bor_low_ok_pin = 1'b1;
    bor_sel_ok_pin = 1'b1;
    wt(S_DONE, 1'b1);
    chk(rtc_reset, 1'h0);
    level_din = 2'h2;
    level_wr  = 1'b1;
    @(negedge clk);
    level_wr     = 1'b0;
    boot_rst_req = 1'b1;
    @(negedge clk);
    boot_rst_req = 1'b0;
    chk(bor_level, LOWEST_BROWNOUT_LEVEL);
    @(negedge clk);
    chk({rtc_reset, boot_done, bor_reset}, 8'h4);
    wt(S_DONE, 1'b1);
    chk(bor_level, LOWEST_BROWNOUT_LEVEL);
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n, por_ok_pin, bor_low_ok_pin, bor_sel_ok_pin, level_wr} = 5'h00;
    {boot_rst_req, sys_rst_req, cpu_rst_req} = 3'h0;
    level_din  = 2'h0;
    err_total  = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_power_up();
    t_level();
    t_swrst();
    t_clocks();
    t_brownout();
    print_verdict();
  end

  // Watchdog against a hang
  initial begin
    #(3000 * 40);
    err_total++;
    print_verdict();
  end
endmodule
